// [src/cie_pkg.sv]
/*
 * constants for the contactless interrupt enable and request block:
 * register offsets, bit positions and reset values.
 * assumes an 8-bit register port with byte offsets as printed.
 */
package cie_pkg;
    localparam logic [7:0] CIE_ADDR_COMMON_EN  = 8'hd2;
    localparam logic [7:0] CIE_ADDR_MISC_EN    = 8'hd3;
    localparam logic [7:0] CIE_ADDR_COMMON_REQ = 8'hd4;
    localparam logic [7:0] CIE_ADDR_MISC_REQ   = 8'hd5;

    localparam int CIE_COMMON_W = 7;
    localparam int CIE_MISC_W   = 5;
    localparam int CIE_POL_BIT  = 7;

    // common register bit positions
    localparam int CIE_B_TX    = 6;
    localparam int CIE_B_RX    = 5;
    localparam int CIE_B_IDLE  = 4;
    localparam int CIE_B_HIGH  = 3;
    localparam int CIE_B_LOW   = 2;
    localparam int CIE_B_ERR   = 1;
    localparam int CIE_B_TIMER = 0;
    // misc register bit positions
    localparam int CIE_B_LINK  = 4;
    localparam int CIE_B_MODE  = 3;
    localparam int CIE_B_CSUM  = 2;
    localparam int CIE_B_FON   = 1;
    localparam int CIE_B_FOFF  = 0;

    localparam logic [7:0] CIE_RST_COMMON_EN  = 8'h00;
    localparam logic [7:0] CIE_RST_MISC_EN    = 8'h00;
    localparam logic [7:0] CIE_RST_COMMON_REQ = 8'h14;
    localparam logic [7:0] CIE_RST_MISC_REQ   = 8'h00;

    // flags routed to line one; the rest of the common set goes to line zero
    localparam logic [6:0] CIE_LINE_ONE_MASK = 7'h6c;
endpackage

// [src/cie_flag_if.sv]
/*
 * carrier between the top and a sticky flag store.
 * assumes one clock domain; the top drives writes and hardware sets.
 */
`timescale 1ns/1ps
interface cie_flag_if #(
    parameter int W = 7
);
    logic         wr;
    logic [7:0]   wdata;
    logic [W-1:0] hw_set;
    logic [W-1:0] q;

    modport owner (output wr, output wdata, output hw_set, input q);
    modport store (input wr, input wdata, input hw_set, output q);
endinterface

// [src/cie_flag_reg.sv]
/*
 * sticky request flags with polarity-bit writes.
 * assumes wr is a one-cycle pulse from the register port.
 */
`timescale 1ns/1ps
module cie_flag_reg
    import cie_pkg::*;
#(
    parameter int         W   = 7,
    parameter logic [7:0] RST = 8'h00
)(
    input  wire logic clk_sys,  // system clock
    input  wire logic rst,      // async reset, active high
    cie_flag_if.store f         // write and set port
);
    initial
    begin
        if (W < 1 || W > CIE_POL_BIT)
            $error("cie_flag_reg: width must be 1 to 7");
    end

    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;
    wire  [W-1:0] wr_sel = f.wr ? f.wdata[W-1:0] : '0;
    wire          pol    = f.wdata[CIE_POL_BIT];

    // hardware set is or-ed last so an event in a clearing cycle survives
    assign q_nxt = (pol ? (q_r | wr_sel) : (q_r & ~wr_sel)) | f.hw_set;
    assign f.q   = q_r;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            q_r <= RST[W-1:0];
        else
            q_r <= q_nxt;
    end
endmodule

// [src/cie_irq_top.sv]
/*
 * contactless interrupt enable and request logic: two enable registers,
 * common and misc request flags, two interrupt lines.
 * assumes all event inputs are synchronous to clk_sys; event pulses
 * are one cycle long, status inputs are levels.
 */
// Our own choice: strobed register access.
`timescale 1ns/1ps
module cie_irq_top
    import cie_pkg::*;
#(
    parameter int TIMER_W = 16
)(
    input  wire logic               clk_sys,            // system clock
    input  wire logic               rst,                // async reset, active high
    input  wire logic [7:0]         reg_addr,           // register address
    input  wire logic [7:0]         reg_wdata,          // write data
    input  wire logic               reg_wr,             // write strobe
    input  wire logic               reg_rd,             // read strobe
    output logic      [7:0]         reg_rdata,          // read data, cycle after strobe
    input  wire logic               tx_last_bit_sent,   // pulse: last bit left transmitter
    input  wire logic               rx_stream_end,      // pulse: valid stream end seen
    input  wire logic               rx_only_with_bytes, // level: require fifo data
    input  wire logic               fifo_has_bytes,     // level: fifo not empty
    input  wire logic               cmd_ended_self,     // pulse: command went idle itself
    input  wire logic               cmd_unknown_start,  // pulse: unknown code started
    input  wire logic               cmd_cpu_idle,       // pulse: processor wrote idle
    output logic                    cmd_force_idle,     // pulse: put command back to idle
    input  wire logic               fifo_high_status,   // level: fifo high alert
    input  wire logic               fifo_low_status,    // level: fifo low alert
    input  wire logic [7:0]         error_bits,         // error register contents
    input  wire logic [TIMER_W-1:0] timer_current_count, // timer value
    input  wire logic               secure_link_input,  // secure link signal
    input  wire logic               mode_detected,      // pulse: mode detected
    input  wire logic               checksum_done,      // pulse: checksum finished
    input  wire logic               field_present,      // level: external field seen
    output logic                    irq_out_zero,       // interrupt line zero
    output logic                    irq_out_one         // interrupt line one
);
    // exact byte compare; the write decode and the read mux share it
    function automatic logic hit(
        input logic [7:0] a,
        input logic [7:0] ref_a
    );
        hit = (a == ref_a);
    endfunction

    // tx, rx and both fifo alerts are the only common flags on line one
    function automatic logic to_line_one(input int b);
        to_line_one = (b == CIE_B_TX) || (b == CIE_B_RX) ||
                      (b == CIE_B_HIGH) || (b == CIE_B_LOW);
    endfunction

    // the same routing as a mask, so the package constant can be checked
    function automatic logic [CIE_COMMON_W-1:0] line_one_mask();
        logic [CIE_COMMON_W-1:0] m;
        m = '0;
        for (int b = 0; b < CIE_COMMON_W; b++)
        begin
            m[b] = to_line_one(b);
        end
        line_one_mask = m;
    endfunction

    initial
    begin
        if (TIMER_W < 1 || TIMER_W > 32)
            $error("cie_irq_top: timer width must be 1 to 32");
        if (CIE_COMMON_W != 7)
            $error("cie_irq_top: common flag set must be 7 bits");
        if (CIE_MISC_W != 5)
            $error("cie_irq_top: misc flag set must be 5 bits");
        if (CIE_POL_BIT != 7)
            $error("cie_irq_top: polarity must sit on bit 7");
        if (CIE_LINE_ONE_MASK != line_one_mask())
            $error("cie_irq_top: line one mask disagrees with bit map");
        if (CIE_B_TX >= CIE_COMMON_W || CIE_B_RX >= CIE_COMMON_W)
            $error("cie_irq_top: common bit position out of range");
        if (CIE_B_IDLE >= CIE_COMMON_W || CIE_B_HIGH >= CIE_COMMON_W)
            $error("cie_irq_top: common bit position out of range");
        if (CIE_B_LOW >= CIE_COMMON_W || CIE_B_ERR >= CIE_COMMON_W)
            $error("cie_irq_top: common bit position out of range");
        if (CIE_B_TIMER >= CIE_COMMON_W)
            $error("cie_irq_top: common bit position out of range");
        if (CIE_B_LINK >= CIE_MISC_W || CIE_B_MODE >= CIE_MISC_W)
            $error("cie_irq_top: misc bit position out of range");
        if (CIE_B_CSUM >= CIE_MISC_W || CIE_B_FON >= CIE_MISC_W)
            $error("cie_irq_top: misc bit position out of range");
        if (CIE_B_FOFF >= CIE_MISC_W)
            $error("cie_irq_top: misc bit position out of range");
    end

    // decode: one select per register, the write strobe qualifies it
    wire sel_cen  = hit(reg_addr, CIE_ADDR_COMMON_EN);
    wire sel_men  = hit(reg_addr, CIE_ADDR_MISC_EN);
    wire sel_creq = hit(reg_addr, CIE_ADDR_COMMON_REQ);
    wire sel_mreq = hit(reg_addr, CIE_ADDR_MISC_REQ);
    wire wr_cen   = reg_wr && sel_cen;
    wire wr_men   = reg_wr && sel_men;
    wire wr_creq  = reg_wr && sel_creq;
    wire wr_mreq  = reg_wr && sel_mreq;

    // enable registers
    logic [CIE_COMMON_W-1:0] common_irq_enable_r;
    logic [CIE_MISC_W-1:0]   misc_irq_enable_r;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            common_irq_enable_r <= CIE_RST_COMMON_EN[CIE_COMMON_W-1:0];
        end
        else if (wr_cen)
        begin
            common_irq_enable_r <= reg_wdata[CIE_COMMON_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            misc_irq_enable_r <= CIE_RST_MISC_EN[CIE_MISC_W-1:0];
        end
        else if (wr_men)
        begin
            misc_irq_enable_r <= reg_wdata[CIE_MISC_W-1:0];
        end
    end

    // previous-cycle copies for edge detection
    logic               high_d_r;
    logic               low_d_r;
    logic               link_d_r;
    logic               field_d_r;
    logic               timer_nz_r;

    // memories start low, so a level already high after reset counts as an edge
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            high_d_r <= 1'b0;
        end
        else
        begin
            high_d_r <= fifo_high_status;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            low_d_r <= 1'b0;
        end
        else
        begin
            low_d_r <= fifo_low_status;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            link_d_r <= 1'b0;
        end
        else
        begin
            link_d_r <= secure_link_input;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            field_d_r <= 1'b0;
        end
        else
        begin
            field_d_r <= field_present;
        end
    end

    // a count that sits at zero sets the flag only once, on arrival
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            timer_nz_r <= 1'b0;
        end
        else
        begin
            timer_nz_r <= (timer_current_count != '0);
        end
    end

    // common events
    wire ev_tx    = tx_last_bit_sent;
    // receive-done is held back while bytes are demanded and none are there
    wire rx_allowed = !rx_only_with_bytes || fifo_has_bytes;
    wire ev_rx    = rx_stream_end && rx_allowed;
    // a processor idle write is not a self-ending command, so it sets nothing
    wire idle_self = cmd_ended_self && !cmd_cpu_idle;
    wire ev_idle  = idle_self || cmd_unknown_start;
    wire ev_high  = fifo_high_status && !high_d_r;
    wire ev_low   = fifo_low_status && !low_d_r;
    wire ev_err   = |error_bits;
    wire ev_timer = timer_nz_r && (timer_current_count == '0);

    // misc events
    wire ev_link  = secure_link_input ^ link_d_r;
    wire ev_fon   = field_present && !field_d_r;
    wire ev_foff  = !field_present && field_d_r;

    assign cmd_force_idle = cmd_unknown_start;

    cie_flag_if #(.W(CIE_COMMON_W)) creq_if ();
    cie_flag_if #(.W(CIE_MISC_W))   mreq_if ();

    // hardware sets placed by bit position, not by concatenation order
    logic [CIE_COMMON_W-1:0] c_set;
    logic [CIE_MISC_W-1:0]   m_set;

    always_comb
    begin
        c_set              = '0;
        c_set[CIE_B_TX]    = ev_tx;
        c_set[CIE_B_RX]    = ev_rx;
        c_set[CIE_B_IDLE]  = ev_idle;
        c_set[CIE_B_HIGH]  = ev_high;
        c_set[CIE_B_LOW]   = ev_low;
        c_set[CIE_B_ERR]   = ev_err;
        c_set[CIE_B_TIMER] = ev_timer;
    end

    always_comb
    begin
        m_set             = '0;
        m_set[CIE_B_LINK] = ev_link;
        m_set[CIE_B_MODE] = mode_detected;
        m_set[CIE_B_CSUM] = checksum_done;
        m_set[CIE_B_FON]  = ev_fon;
        m_set[CIE_B_FOFF] = ev_foff;
    end

    assign creq_if.wr     = wr_creq;
    assign creq_if.wdata  = reg_wdata;
    assign creq_if.hw_set = c_set;
    assign mreq_if.wr     = wr_mreq;
    assign mreq_if.wdata  = reg_wdata;
    assign mreq_if.hw_set = m_set;

    cie_flag_reg #(
        .W   (CIE_COMMON_W),
        .RST (CIE_RST_COMMON_REQ)
    ) u_common_req (
        .clk_sys (clk_sys),
        .rst     (rst),
        .f       (creq_if.store)
    );

    cie_flag_reg #(
        .W   (CIE_MISC_W),
        .RST (CIE_RST_MISC_REQ)
    ) u_misc_req (
        .clk_sys (clk_sys),
        .rst     (rst),
        .f       (mreq_if.store)
    );

    // routing: each flag is masked by its own enable, then or-ed per line
    logic [CIE_COMMON_W-1:0] c_act;
    logic [CIE_COMMON_W-1:0] c_one;
    logic [CIE_COMMON_W-1:0] c_zero;
    logic [CIE_MISC_W-1:0]   m_act;

    genvar gc;
    generate
        for (gc = 0; gc < CIE_COMMON_W; gc++)
        begin : g_common_route
            assign c_act[gc]  = creq_if.q[gc] & common_irq_enable_r[gc];
            assign c_one[gc]  = c_act[gc] & to_line_one(gc);
            assign c_zero[gc] = c_act[gc] & !to_line_one(gc);
        end
    endgenerate

    genvar gm;
    generate
        for (gm = 0; gm < CIE_MISC_W; gm++)
        begin : g_misc_route
            // every misc flag goes to line zero
            assign m_act[gm] = mreq_if.q[gm] & misc_irq_enable_r[gm];
        end
    endgenerate

    wire line_one_nxt  = |c_one;
    wire line_zero_nxt = (|c_zero) || (|m_act);

    // read mux; polarity and reserved bits read zero
    logic [7:0] rd_nxt;

    always_comb
    begin
        rd_nxt = 8'h00;
        if (sel_cen)
        begin
            rd_nxt = {1'b0, common_irq_enable_r};
        end
        else if (sel_men)
        begin
            rd_nxt = {3'b000, misc_irq_enable_r};
        end
        else if (sel_creq)
        begin
            rd_nxt = {1'b0, creq_if.q};
        end
        else if (sel_mreq)
        begin
            rd_nxt = {3'b000, mreq_if.q};
        end
    end

    // read data stand for one cycle and are zero otherwise
    wire [7:0] rd_word = reg_rd ? rd_nxt : 8'h00;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= rd_word;
    end

    // registered lines cost a cycle but keep glitches off the pins
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            irq_out_zero <= 1'b0;
        else
            irq_out_zero <= line_zero_nxt;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            irq_out_one <= 1'b0;
        else
            irq_out_one <= line_one_nxt;
    end
endmodule

// [testbench/cie_irq_sva.sv]
/*
 * concurrent checks on the ports of cie_irq_top.
 * assumes one clock domain; enable registers are shadowed from port writes.
 */
`timescale 1ns/1ps
module cie_irq_sva
    import cie_pkg::*;
(
    input wire logic       clk_sys,            // clock
    input wire logic       rst,                // reset
    input wire logic [7:0] reg_addr,           // address
    input wire logic [7:0] reg_wdata,          // write data
    input wire logic       reg_wr,             // write strobe
    input wire logic       reg_rd,             // read strobe
    input wire logic [7:0] reg_rdata,          // read data
    input wire logic       tx_last_bit_sent,   // tx event
    input wire logic       rx_stream_end,      // rx event
    input wire logic       rx_only_with_bytes, // rx option
    input wire logic       fifo_has_bytes,     // fifo level
    input wire logic       cmd_ended_self,     // idle event
    input wire logic       cmd_cpu_idle,       // cpu idle
    input wire logic       cmd_unknown_start,  // unknown command
    input wire logic       cmd_force_idle,     // force idle
    input wire logic [7:0] error_bits,         // errors
    input wire logic       field_present,      // field level
    input wire logic       irq_out_zero,       // line zero
    input wire logic       irq_out_one         // line one
);
    logic [6:0] en_c_r;
    logic [4:0] en_m_r;
    wire        wc = reg_wr && reg_addr == CIE_ADDR_COMMON_EN;
    wire        wm = reg_wr && reg_addr == CIE_ADDR_MISC_EN;
    // shadowing the enables keeps the checker free of hierarchical paths
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
            {en_c_r, en_m_r} <= 12'h000;
        else
            {en_c_r, en_m_r} <= {wc ? reg_wdata[6:0] : en_c_r, wm ? reg_wdata[4:0] : en_m_r};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_TX_LINE: assert property (tx_last_bit_sent && en_c_r[6] && !wc |-> ##2 irq_out_one)
        else $error("tx event did not reach line one");
    AST_RX_LINE: assert property (rx_stream_end && (!rx_only_with_bytes || fifo_has_bytes)
        && en_c_r[5] && !wc |-> ##2 irq_out_one) else $error("rx event did not reach line one");
    AST_IDLE_LINE: assert property (cmd_ended_self && !cmd_cpu_idle && en_c_r[4] && !wc
        |-> ##2 irq_out_zero) else $error("idle event did not reach line zero");
    AST_ERR_LINE: assert property (error_bits != 8'h00 && en_c_r[1] && !wc |-> ##2 irq_out_zero)
        else $error("error did not reach line zero");
    AST_FIELD_LINE: assert property ($rose(field_present) && en_m_r[1] && !wm
        |-> ##2 irq_out_zero) else $error("field on did not reach line zero");
    AST_FORCE_IDLE: assert property (cmd_force_idle == cmd_unknown_start)
        else $error("force idle does not follow unknown command");
    AST_ONE_QUIET: assert property ((en_c_r & 7'h6c) == 7'h00 |=> !irq_out_one)
        else $error("line one high with its enables off");
    AST_ZERO_QUIET: assert property ((en_c_r & 7'h13) == 7'h00 && en_m_r == 5'h00
        |=> !irq_out_zero) else $error("line zero high with its enables off");
    AST_EN_READ: assert property (reg_rd && reg_addr == CIE_ADDR_COMMON_EN
        |=> reg_rdata == {1'b0, en_c_r}) else $error("common enable read back wrong");
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    COV_TX: cover property (tx_last_bit_sent && en_c_r[6]);
    COV_FIELD: cover property ($rose(field_present) && en_m_r[1]);
    COV_FORCE: cover property (cmd_force_idle);
endmodule
bind cie_irq_top cie_irq_sva u_sva (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .tx_last_bit_sent, .rx_stream_end, .rx_only_with_bytes, .fifo_has_bytes,
    .cmd_ended_self, .cmd_cpu_idle, .cmd_unknown_start, .cmd_force_idle, .error_bits,
    .field_present, .irq_out_zero, .irq_out_one);

// [testbench/tb.sv]
/*
 * self-checking bench for cie_irq_top: register port tasks and event tests.
 * assumes the checker is bound by its own file.
 */
`timescale 1ns/1ps
module tb
    import cie_pkg::*;
();
    logic        clk_sys, rst, reg_wr, reg_rd, rx_only_with_bytes, fifo_has_bytes;
    logic        tx_last_bit_sent, rx_stream_end, cmd_ended_self, cmd_unknown_start;
    logic        cmd_cpu_idle, fifo_high_status, fifo_low_status, secure_link_input;
    logic        mode_detected, checksum_done, field_present, cmd_force_idle;
    logic        irq_out_zero, irq_out_one;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, error_bits;
    logic [15:0] timer_current_count;
    logic [7:0]  exp_t [7] = '{8'h40, 8'h20, 8'h10, 8'h10, 8'h08, 8'h04, 8'h00};
    int          fails, compares;
    cie_irq_top dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .tx_last_bit_sent, .rx_stream_end, .rx_only_with_bytes, .fifo_has_bytes,
        .cmd_ended_self, .cmd_unknown_start, .cmd_cpu_idle, .cmd_force_idle,
        .fifo_high_status, .fifo_low_status, .error_bits, .timer_current_count,
        .secure_link_input, .mode_detected, .checksum_done, .field_present,
        .irq_out_zero, .irq_out_one);
    task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, exp, got);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", reg_rdata, e);
    endtask
    task line(input logic one, input logic zero);
        @(posedge clk_sys);
        #1;
        chk("irq_out_one", {7'h00, irq_out_one}, {7'h00, one});
        chk("irq_out_zero", {7'h00, irq_out_zero}, {7'h00, zero});
    endtask
    // one event pulse per call, two for case 6 (self-end with processor idle), so flags are seen one source at a time
    task ev(input int k);
        @(posedge clk_sys);
        case (k)
            0: tx_last_bit_sent <= 1'b1;
            1: rx_stream_end <= 1'b1;
            2: cmd_ended_self <= 1'b1;
            3: cmd_unknown_start <= 1'b1;
            4: mode_detected <= 1'b1;
            5: checksum_done <= 1'b1;
            default: {cmd_ended_self, cmd_cpu_idle} <= 2'b11;
        endcase
        #1;
        chk("cmd_force_idle", {7'h00, cmd_force_idle}, {7'h00, k == 3});
        @(posedge clk_sys);
        {tx_last_bit_sent, rx_stream_end, cmd_ended_self, cmd_unknown_start} <= 4'h0;
        {mode_detected, checksum_done, cmd_cpu_idle} <= 3'h0;
    endtask
    task clr;
        wr(CIE_ADDR_COMMON_REQ, 8'h7f);
        wr(CIE_ADDR_MISC_REQ, 8'h1f);
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        stop_test;
    end
    initial
    begin
        {rst, fails, compares, timer_current_count} = {1'b1, 64'h0, 16'h0005};
        {reg_wr, reg_rd, reg_addr, reg_wdata, error_bits, rx_only_with_bytes} = '0;
        {fifo_has_bytes, tx_last_bit_sent, rx_stream_end, cmd_ended_self} = '0;
        {cmd_unknown_start, cmd_cpu_idle, fifo_high_status, fifo_low_status} = '0;
        {secure_link_input, mode_detected, checksum_done, field_present} = '0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        rd(CIE_ADDR_COMMON_EN, 8'h00);
        rd(CIE_ADDR_MISC_EN, 8'h00);
        rd(CIE_ADDR_COMMON_REQ, 8'h14);
        wr(8'hd7, 8'hff);
        rd(8'hd7, 8'h00);
        wr(CIE_ADDR_COMMON_REQ, 8'h7f);
        rd(CIE_ADDR_COMMON_REQ, 8'h00);
        wr(CIE_ADDR_COMMON_REQ, 8'h85);
        rd(CIE_ADDR_COMMON_REQ, 8'h05);
        wr(CIE_ADDR_COMMON_REQ, 8'h01);
        rd(CIE_ADDR_COMMON_REQ, 8'h04);
        $display("test registers finished");
        clr;
        wr(CIE_ADDR_COMMON_EN, 8'h40);
        wr(CIE_ADDR_COMMON_REQ, 8'hc0);
        line(1'b1, 1'b0);
        wr(CIE_ADDR_COMMON_EN, 8'h10);
        line(1'b0, 1'b0);
        wr(CIE_ADDR_COMMON_REQ, 8'h90);
        line(1'b0, 1'b1);
        clr;
        wr(CIE_ADDR_COMMON_EN, 8'h00);
        wr(CIE_ADDR_MISC_EN, 8'h08);
        wr(CIE_ADDR_MISC_REQ, 8'h88);
        line(1'b0, 1'b1);
        wr(CIE_ADDR_MISC_EN, 8'h00);
        line(1'b0, 1'b0);
        clr;
        wr(CIE_ADDR_COMMON_EN, 8'h04);
        wr(CIE_ADDR_COMMON_REQ, 8'h84);
        line(1'b1, 1'b0);
        wr(CIE_ADDR_COMMON_EN, 8'h01);
        wr(CIE_ADDR_COMMON_REQ, 8'h81);
        line(1'b0, 1'b1);
        $display("test lines finished");
        wr(CIE_ADDR_COMMON_EN, 8'hff);
        rd(CIE_ADDR_COMMON_EN, 8'h7f);
        wr(CIE_ADDR_MISC_EN, 8'hff);
        rd(CIE_ADDR_MISC_EN, 8'h1f);
        for (int i = 0; i < 7; i++)
        begin
            clr;
            ev(i);
            rd((i == 4 || i == 5) ? CIE_ADDR_MISC_REQ : CIE_ADDR_COMMON_REQ, exp_t[i]);
        end
        rx_only_with_bytes <= 1'b1;
        clr;
        ev(1);
        rd(CIE_ADDR_COMMON_REQ, 8'h00);
        fifo_has_bytes <= 1'b1;
        ev(1);
        rd(CIE_ADDR_COMMON_REQ, 8'h20);
        clr;
        {fifo_high_status, fifo_low_status} <= 2'b11;
        rd(CIE_ADDR_COMMON_REQ, 8'h0c);
        {fifo_high_status, fifo_low_status} <= 2'b00;
        rd(CIE_ADDR_COMMON_REQ, 8'h0c);
        clr;
        error_bits <= 8'h80;
        rd(CIE_ADDR_COMMON_REQ, 8'h02);
        error_bits <= 8'h00;
        clr;
        timer_current_count <= 16'h0000;
        rd(CIE_ADDR_COMMON_REQ, 8'h01);
        clr;
        rd(CIE_ADDR_COMMON_REQ, 8'h00);
        secure_link_input <= 1'b1;
        rd(CIE_ADDR_MISC_REQ, 8'h10);
        clr;
        secure_link_input <= 1'b0;
        rd(CIE_ADDR_MISC_REQ, 8'h10);
        clr;
        field_present <= 1'b1;
        rd(CIE_ADDR_MISC_REQ, 8'h02);
        clr;
        field_present <= 1'b0;
        rd(CIE_ADDR_MISC_REQ, 8'h01);
        $display("test events finished");
        stop_test;
    end
endmodule
